// ==== rtl/rxfcg_pkg.sv ====
// Package of constants and types for the receiver filter calibration and gain control block
package rxfcg_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_OVERRIDE = 8'h00; // Calibration override / trim control
	localparam logic [7:0] OFS_STATUS = 8'h04; // Filter calibration status, read-only
	localparam logic [7:0] OFS_IQ = 8'h08; // I/Q calibration control and value
	localparam logic [7:0] OFS_GAIN = 8'h0c; // High / low gain settings
	localparam logic [7:0] OFS_BW = 8'h10; // Channel filter bandwidth
	localparam logic [7:0] OFS_RXCTL = 8'h14; // Receive request and front-end state
	// ==========================================================
	// Override register fields
	localparam int OV_SKIP = 0;
	localparam int OV_FORCE = 1;
	localparam int OV_TRIM_LO = 2;
	localparam int OV_MAN_LO = 4;
	// Status register fields
	localparam int ST_RUN = 0;
	localparam int ST_VALID = 1;
	localparam int ST_RES_LO = 4;
	// I/Q register fields
	localparam int IQ_START = 0;
	localparam int IQ_RUN = 1;
	localparam int IQ_VAL_LO = 8;
	// Gain register fields: high set then low set, each filter gain then amplifier gain
	localparam int GN_HI_CF = 0;
	localparam int GN_HI_LNA = 2;
	localparam int GN_LO_CF = 4;
	localparam int GN_LO_LNA = 6;
	localparam int GN_AUTO = 8;
	// Receive control fields
	localparam int RX_REQ = 0;
	localparam int RX_GAP = 4;
	localparam int RX_CLK = 5;
	localparam int RX_ON = 6;
	// ==========================================================
	// Reset values
	localparam logic [3:0] RESULT_RST = 4'h8;
	localparam logic [2:0] BW_RST = 3'h0;
	localparam logic [7:0] GAIN_RST = 8'h0f;
	// ==========================================================
	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int SETTLE_NS = 1000; // Bandgap settle time
	localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// ==========================================================
	// Filter calibration sequencer states
	typedef enum logic [2:0] {
		RXFCG_IDLE, RXFCG_SETTLE, RXFCG_CAL, RXFCG_CLKOFF, RXFCG_LOCKWAIT, RXFCG_RXON
	} rxfcg_fstate_t;
	// I/Q sweep states
	typedef enum logic [1:0] {
		RXFCG_IQ_IDLE, RXFCG_IQ_STEP, RXFCG_IQ_MEAS
	} rxfcg_iqstate_t;
endpackage

// ==== rtl/rxfcg_sync.sv ====
// Two-flop synchroniser bank for external inputs
`timescale 1ns/1ps
`default_nettype none
module rxfcg_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q, s1_d; // First stage, read only by second
	logic [W-1:0] s2_q, s2_d; // Second stage

	// ==========================================================
	// Next values
	always_comb begin
		s1_d = din;
		s2_d = s1_q;
	end

	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign dout = s2_q;
endmodule
`default_nettype wire

// ==== rtl/rxfcg_top.sv ====
// Receiver filter calibration, I/Q calibration and gain control logic
// Notes on behaviour
// - Calibrate filter before every receive
// - Skip bit bypasses calibration on receive entry; a forced run still calibrates
// - Force bit triggers calibration any time; the code acts on it only in the idle state, so during a receive it waits
// - Running flag high during calibration
// - Valid flag set on good completion
// - Result drives filter RC components
// - Status register bits are read-only
// - Trim adjust shifts calibration reference
// - Start bit begins I/Q calibration
// - I/Q running flag during sweep
// - Sweep all offsets, measure each
// - Keep lowest-strength offset as value
// - Filter gain code maps to dB
// - Amplifier gain code maps to dB
// - Loop picks high or low gain
// - Bandwidth field independent of gain
// - Limiter I/Q sampled as bits
// - Calibrate, wait, gate clock off
// - Wait 1 us after bandgap on
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rxfcg_top #(
	parameter int IQW = 7, // I/Q offset code width
	parameter int MEAS_CYC = 16 // Cycles per strength measurement
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog calibration comparator and lock status
	input wire logic cal_cmp_done,
	input wire logic [3:0] cal_cmp_code,
	input wire logic synth_locked_state,
	// Signal strength and gain loop
	input wire logic [7:0] rssi_level,
	input wire logic gain_low_sel,
	// Limiter square waves
	input wire logic lim_i,
	input wire logic lim_q,
	// Analog controls
	output logic rx_bandgap_enable,
	output logic cal_clock_enable,
	output logic cal_engine_start,
	output logic [1:0] filter_cal_trim_adjust,
	output logic [3:0] filter_rc_code,
	output logic [IQW-1:0] iq_offset_code,
	output logic [1:0] filter_gain_code,
	output logic [1:0] lna_gain_code,
	output logic [2:0] filter_bandwidth_sel,
	output logic rx_enable,
	// Limiter bits to demodulator
	output logic demod_i,
	output logic demod_q
);
	// ==========================================================
	// Functions
	// Word aligned address match
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		addr_hit = (a[7:2] == ofs[7:2]);
	endfunction

	// ==========================================================
	// Synchronised inputs
	logic [16:0] sync_out; // Synchronised external inputs
	logic cmp_done_s, locked_s, gain_low_s;
	logic [3:0] cmp_code_s;
	logic [7:0] rssi_s;
	logic lim_i_s, lim_q_s;

	rxfcg_sync #(.W(17)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({cal_cmp_done, cal_cmp_code, synth_locked_state, rssi_level, gain_low_sel, lim_i,
			lim_q}),
		.dout(sync_out)
	);
	assign {cmp_done_s, cmp_code_s, locked_s, rssi_s, gain_low_s, lim_i_s, lim_q_s} = sync_out;

	// ==========================================================
	// Register state
	logic skip_q, skip_d; // Skip control
	logic force_q, force_d; // Force trigger
	logic [1:0] trim_q, trim_d; // Reference trim
	logic [3:0] man_q, man_d; // Manual RC value
	logic iqstart_q, iqstart_d; // I/Q start trigger
	logic [IQW-1:0] iqval_q, iqval_d; // I/Q value
	logic [7:0] gain_q, gain_d; // Gain settings
	logic auto_q, auto_d; // Automatic gain loop enable
	logic [2:0] bw_q, bw_d; // Bandwidth
	logic rxreq_q, rxreq_d; // Receive request
	// Calibration state
	rxfcg_pkg::rxfcg_fstate_t fst_q, fst_d;
	logic frun_q, frun_d; // Filter running
	logic fvalid_q, fvalid_d; // Result valid
	logic [3:0] fres_q, fres_d; // Result
	logic [$clog2(rxfcg_pkg::SETTLE_CYC+1)-1:0] set_q, set_d; // Settle counter
	logic gap_q, gap_d, clk_q, clk_d, rxon_q, rxon_d, cstart_q, cstart_d;
	logic forced_q, forced_d; // Calibration started by force, not receive
	// I/Q state
	rxfcg_pkg::rxfcg_iqstate_t iqs_q, iqs_d;
	logic [IQW-1:0] iqcur_q, iqcur_d; // Offset under test
	logic [7:0] iqmin_q, iqmin_d; // Lowest reading so far
	logic [$clog2(MEAS_CYC+1)-1:0] mcnt_q, mcnt_d;
	// Bus state
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] fg_q, fg_d, lg_q, lg_d; // Applied gains
	logic di_q, di_d, dq_q, dq_d; // Limiter bits

	logic wr, rd; // Bus strobes
	logic [31:0] st_word, ov_word, iq_word, gn_word, bw_word, rx_word;

	// ==========================================================
	// Bus handshakes: write taken when address and data both present
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_wready = s_axi_awready;
	assign wr = s_axi_awready;
	assign s_axi_arready = s_axi_arvalid && !rvalid_q;
	assign rd = s_axi_arready;

	// Readback words
	always_comb begin
		st_word = '0;
		st_word[rxfcg_pkg::ST_RUN] = frun_q;
		st_word[rxfcg_pkg::ST_VALID] = fvalid_q;
		st_word[rxfcg_pkg::ST_RES_LO +: 4] = fres_q;
		ov_word = '0;
		ov_word[rxfcg_pkg::OV_SKIP] = skip_q;
		ov_word[rxfcg_pkg::OV_FORCE] = force_q;
		ov_word[rxfcg_pkg::OV_TRIM_LO +: 2] = trim_q;
		ov_word[rxfcg_pkg::OV_MAN_LO +: 4] = man_q;
		iq_word = '0;
		iq_word[rxfcg_pkg::IQ_START] = iqstart_q;
		iq_word[rxfcg_pkg::IQ_RUN] = (iqs_q != rxfcg_pkg::RXFCG_IQ_IDLE);
		iq_word[rxfcg_pkg::IQ_VAL_LO +: IQW] = iqval_q;
		gn_word = '0;
		gn_word[7:0] = gain_q;
		gn_word[rxfcg_pkg::GN_AUTO] = auto_q;
		bw_word = '0;
		bw_word[2:0] = bw_q;
		rx_word = '0;
		rx_word[rxfcg_pkg::RX_REQ] = rxreq_q;
		rx_word[rxfcg_pkg::RX_GAP] = gap_q;
		rx_word[rxfcg_pkg::RX_CLK] = clk_q;
		rx_word[rxfcg_pkg::RX_ON] = rxon_q;
	end

	// ==========================================================
	// Software registers and bus responses
	always_comb begin
		skip_d = skip_q;
		force_d = force_q;
		trim_d = trim_q;
		man_d = man_q;
		iqstart_d = iqstart_q;
		iqval_d = iqval_q;
		gain_d = gain_q;
		auto_d = auto_q;
		bw_d = bw_q;
		rxreq_d = rxreq_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !s_axi_rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		// Triggers clear once their calibration has begun
		if (fst_q == rxfcg_pkg::RXFCG_CAL && forced_q) force_d = 1'b0;
		if (iqs_q == rxfcg_pkg::RXFCG_IQ_STEP) iqstart_d = 1'b0;
		if (wr) begin
			bvalid_d = 1'b1;
			bresp_d = rxfcg_pkg::AXI_OKAY;
			if (s_axi_wstrb[0]) begin
				if (addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_OVERRIDE)) begin
					skip_d = s_axi_wdata[rxfcg_pkg::OV_SKIP];
					force_d = force_d | s_axi_wdata[rxfcg_pkg::OV_FORCE];
					trim_d = s_axi_wdata[rxfcg_pkg::OV_TRIM_LO +: 2];
					man_d = s_axi_wdata[rxfcg_pkg::OV_MAN_LO +: 4];
				end else if (addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_IQ)) begin
					iqstart_d = iqstart_d | s_axi_wdata[rxfcg_pkg::IQ_START];
				end else if (addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_GAIN)) begin
					gain_d = s_axi_wdata[7:0];
				end else if (addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_BW)) begin
					bw_d = s_axi_wdata[2:0];
				end else if (addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_RXCTL)) begin
					rxreq_d = s_axi_wdata[rxfcg_pkg::RX_REQ];
				end
			end
			// Value field sits in byte 1, restored by host at init
			if (s_axi_wstrb[1] && addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_IQ)) begin
				iqval_d = s_axi_wdata[rxfcg_pkg::IQ_VAL_LO +: IQW];
			end
			if (s_axi_wstrb[1] && addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_GAIN)) begin
				auto_d = s_axi_wdata[rxfcg_pkg::GN_AUTO];
			end
			// Status writes are accepted but change nothing
			if (!(addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_OVERRIDE)
				|| addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_STATUS)
				|| addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_IQ)
				|| addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_GAIN)
				|| addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_BW)
				|| addr_hit(s_axi_awaddr, rxfcg_pkg::OFS_RXCTL))) begin
				bresp_d = rxfcg_pkg::AXI_SLVERR;
			end
		end
		// Value field takes each new lowest-strength offset as soon as it is measured during the sweep
		if (iqs_q == rxfcg_pkg::RXFCG_IQ_MEAS && mcnt_q == '0 && rssi_s < iqmin_q) begin
			iqval_d = iqcur_q;
		end
		if (rd) begin
			rvalid_d = 1'b1;
			rresp_d = rxfcg_pkg::AXI_OKAY;
			if (addr_hit(s_axi_araddr, rxfcg_pkg::OFS_OVERRIDE)) rdata_d = ov_word;
			else if (addr_hit(s_axi_araddr, rxfcg_pkg::OFS_STATUS)) rdata_d = st_word;
			else if (addr_hit(s_axi_araddr, rxfcg_pkg::OFS_IQ)) rdata_d = iq_word;
			else if (addr_hit(s_axi_araddr, rxfcg_pkg::OFS_GAIN)) rdata_d = gn_word;
			else if (addr_hit(s_axi_araddr, rxfcg_pkg::OFS_BW)) rdata_d = bw_word;
			else if (addr_hit(s_axi_araddr, rxfcg_pkg::OFS_RXCTL)) rdata_d = rx_word;
			else begin
				rdata_d = '0;
				rresp_d = rxfcg_pkg::AXI_SLVERR;
			end
		end
	end

	// ==========================================================
	// Filter calibration and receive entry sequencer
	always_comb begin
		fst_d = fst_q;
		frun_d = frun_q;
		fvalid_d = fvalid_q;
		fres_d = fres_q;
		set_d = set_q;
		gap_d = gap_q;
		clk_d = clk_q;
		rxon_d = rxon_q;
		cstart_d = 1'b0;
		forced_d = forced_q;
		case (fst_q)
			rxfcg_pkg::RXFCG_IDLE: begin
				if (force_q) begin
					// Forced run, independent of receive
					clk_d = 1'b1;
					frun_d = 1'b1;
					cstart_d = 1'b1;
					forced_d = 1'b1;
					fst_d = rxfcg_pkg::RXFCG_CAL;
				end else if (rxreq_q) begin
					gap_d = 1'b1;
					clk_d = !skip_q;
					set_d = $bits(set_q)'(rxfcg_pkg::SETTLE_CYC);
					forced_d = 1'b0;
					fst_d = rxfcg_pkg::RXFCG_SETTLE;
				end
			end
			rxfcg_pkg::RXFCG_SETTLE: begin
				if (set_q > 1) set_d = set_q - 1'b1;
				else if (skip_q) fst_d = rxfcg_pkg::RXFCG_LOCKWAIT;
				else begin
					frun_d = 1'b1;
					cstart_d = 1'b1;
					fst_d = rxfcg_pkg::RXFCG_CAL;
				end
			end
			rxfcg_pkg::RXFCG_CAL: begin
				if (cmp_done_s) begin
					// Running drops with result and valid update
					frun_d = 1'b0;
					fvalid_d = 1'b1;
					fres_d = cmp_code_s;
					fst_d = rxfcg_pkg::RXFCG_CLKOFF;
				end
			end
			rxfcg_pkg::RXFCG_CLKOFF: begin
				clk_d = 1'b0;
				fst_d = forced_q ? rxfcg_pkg::RXFCG_IDLE : rxfcg_pkg::RXFCG_LOCKWAIT;
			end
			rxfcg_pkg::RXFCG_LOCKWAIT: begin
				if (!rxreq_q) begin
					gap_d = 1'b0;
					fst_d = rxfcg_pkg::RXFCG_IDLE;
				end else if (locked_s) begin
					rxon_d = 1'b1;
					fst_d = rxfcg_pkg::RXFCG_RXON;
				end
			end
			rxfcg_pkg::RXFCG_RXON: begin
				if (!rxreq_q) begin
					rxon_d = 1'b0;
					gap_d = 1'b0;
					fst_d = rxfcg_pkg::RXFCG_IDLE;
				end
			end
			default: fst_d = rxfcg_pkg::RXFCG_IDLE;
		endcase
	end

	// ==========================================================
	// I/Q image rejection sweep
	always_comb begin
		iqs_d = iqs_q;
		iqcur_d = iqcur_q;
		iqmin_d = iqmin_q;
		mcnt_d = mcnt_q;
		case (iqs_q)
			rxfcg_pkg::RXFCG_IQ_IDLE: begin
				if (iqstart_q) begin
					iqcur_d = '0;
					iqmin_d = '1;
					iqs_d = rxfcg_pkg::RXFCG_IQ_STEP;
				end
			end
			rxfcg_pkg::RXFCG_IQ_STEP: begin
				mcnt_d = $bits(mcnt_q)'(MEAS_CYC);
				iqs_d = rxfcg_pkg::RXFCG_IQ_MEAS;
			end
			rxfcg_pkg::RXFCG_IQ_MEAS: begin
				if (mcnt_q != '0) mcnt_d = mcnt_q - 1'b1;
				else begin
					if (rssi_s < iqmin_q) iqmin_d = rssi_s;
					if (iqcur_q == '1) iqs_d = rxfcg_pkg::RXFCG_IQ_IDLE;
					else begin
						iqcur_d = iqcur_q + 1'b1;
						iqs_d = rxfcg_pkg::RXFCG_IQ_STEP;
					end
				end
			end
			default: iqs_d = rxfcg_pkg::RXFCG_IQ_IDLE;
		endcase
	end

	// ==========================================================
	// Gain selection and limiter sampling
	always_comb begin
		if (auto_q && gain_low_s) begin
			fg_d = gain_q[rxfcg_pkg::GN_LO_CF +: 2];
			lg_d = gain_q[rxfcg_pkg::GN_LO_LNA +: 2];
		end else begin
			fg_d = gain_q[rxfcg_pkg::GN_HI_CF +: 2];
			lg_d = gain_q[rxfcg_pkg::GN_HI_LNA +: 2];
		end
		di_d = lim_i_s;
		dq_d = lim_q_s;
	end

	// ==========================================================
	// All registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			skip_q <= 1'b0;
			force_q <= 1'b0;
			trim_q <= '0;
			man_q <= '0;
			iqstart_q <= 1'b0;
			iqval_q <= '0;
			gain_q <= rxfcg_pkg::GAIN_RST;
			auto_q <= 1'b0;
			bw_q <= rxfcg_pkg::BW_RST;
			rxreq_q <= 1'b0;
			fst_q <= rxfcg_pkg::RXFCG_IDLE;
			frun_q <= 1'b0;
			fvalid_q <= 1'b0;
			fres_q <= rxfcg_pkg::RESULT_RST;
			set_q <= '0;
			gap_q <= 1'b0;
			clk_q <= 1'b0;
			rxon_q <= 1'b0;
			cstart_q <= 1'b0;
			forced_q <= 1'b0;
			iqs_q <= rxfcg_pkg::RXFCG_IQ_IDLE;
			iqcur_q <= '0;
			iqmin_q <= '1;
			mcnt_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= rxfcg_pkg::AXI_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= rxfcg_pkg::AXI_OKAY;
			rdata_q <= '0;
			fg_q <= '0;
			lg_q <= '0;
			di_q <= 1'b0;
			dq_q <= 1'b0;
		end else begin
			skip_q <= skip_d;
			force_q <= force_d;
			trim_q <= trim_d;
			man_q <= man_d;
			iqstart_q <= iqstart_d;
			iqval_q <= iqval_d;
			gain_q <= gain_d;
			auto_q <= auto_d;
			bw_q <= bw_d;
			rxreq_q <= rxreq_d;
			fst_q <= fst_d;
			frun_q <= frun_d;
			fvalid_q <= fvalid_d;
			fres_q <= fres_d;
			set_q <= set_d;
			gap_q <= gap_d;
			clk_q <= clk_d;
			rxon_q <= rxon_d;
			cstart_q <= cstart_d;
			forced_q <= forced_d;
			iqs_q <= iqs_d;
			iqcur_q <= iqcur_d;
			iqmin_q <= iqmin_d;
			mcnt_q <= mcnt_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			fg_q <= fg_d;
			lg_q <= lg_d;
			di_q <= di_d;
			dq_q <= dq_d;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign rx_bandgap_enable = gap_q;
	assign cal_clock_enable = clk_q;
	assign cal_engine_start = cstart_q;
	assign filter_cal_trim_adjust = trim_q;
	// Skip selects the manual value, else the calibrated result
	assign filter_rc_code = skip_q ? man_q : fres_q;
	// Sweep drives the offset under test, otherwise the stored value
	assign iq_offset_code = (iqs_q != rxfcg_pkg::RXFCG_IQ_IDLE) ? iqcur_q : iqval_q;
	assign filter_gain_code = fg_q;
	assign lna_gain_code = lg_q;
	assign filter_bandwidth_sel = bw_q;
	assign rx_enable = rxon_q;
	assign demod_i = di_q;
	assign demod_q = dq_q;
endmodule
`default_nettype wire

// ==== bench/rxfcg_checker.sv ====
// Port-level timing checker for the receiver calibration and gain block
`timescale 1ns/1ps
`default_nettype none
module rxfcg_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	// Front-end controls and limiter path
	input wire logic cal_engine_start,
	input wire logic rx_enable,
	input wire logic rx_bandgap_enable,
	input wire logic lim_i,
	input wire logic lim_q,
	input wire logic demod_i,
	input wire logic demod_q
);
	// ==========================================
	// Common clocking
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles since reset release, saturating at three
	logic [1:0] up_q;
	logic [1:0] up_d;
	// Next count
	always_comb begin
		up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
	end
	// Count register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_q <= 2'h0;
		end else begin
			up_q <= up_d;
		end
	end
	// ==========================================
	// Properties
	property p_wr_resp; s_axi_awvalid && s_axi_awready |=> s_axi_bvalid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_err_zero; s_axi_rvalid && s_axi_rresp == rxfcg_pkg::AXI_SLVERR |-> s_axi_rdata == 32'h0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read data not zero");
	property p_start_pulse; cal_engine_start |=> !cal_engine_start; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start longer than a pulse");
	property p_demod_i; up_q == 2'h3 |-> demod_i == $past(lim_i, 3); endproperty
	a_demod_i: assert property (p_demod_i) else $error("in-phase bit wrong");
	property p_demod_q; up_q == 2'h3 |-> demod_q == $past(lim_q, 3); endproperty
	a_demod_q: assert property (p_demod_q) else $error("quadrature bit wrong");
	property p_rx_gap; rx_enable |-> rx_bandgap_enable; endproperty
	a_rx_gap: assert property (p_rx_gap) else $error("receiver on without bandgap");
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the receiver calibration and gain block
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ==========================================
	// Stimulus and observed signals
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, rssi_level = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0, cal_cmp_code = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cal_cmp_done = 1'b0;
	logic synth_locked_state = 1'b0, gain_low_sel = 1'b0, lim_i = 1'b0, lim_q = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, filter_cal_trim_adjust;
	logic [1:0] filter_gain_code, lna_gain_code;
	logic [31:0] s_axi_rdata;
	logic rx_bandgap_enable, cal_clock_enable, cal_engine_start, rx_enable, demod_i, demod_q;
	logic [3:0] filter_rc_code, code;
	logic [6:0] iq_offset_code, tgt = 7'h0;
	logic [2:0] filter_bandwidth_sel, b;
	logic [31:0] d;
	logic [7:0] g;
	logic [1:0] r, t;
	logic seen;
	int fails = 0, checks_done = 0, cyc = 0, n;
	// Design under test, short measurements
	rxfcg_top #(.MEAS_CYC(4)) u_rxfcg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cal_cmp_done, .cal_cmp_code,
		.synth_locked_state, .rssi_level, .gain_low_sel, .lim_i, .lim_q, .rx_bandgap_enable,
		.cal_clock_enable, .cal_engine_start, .filter_cal_trim_adjust, .filter_rc_code,
		.iq_offset_code, .filter_gain_code, .lna_gain_code, .filter_bandwidth_sel, .rx_enable,
		.demod_i, .demod_q);
	// Clock
	always #20 aclk = ~aclk;
	// Random limiter bits, strength with one minimum at the target code, hang limit
	always @(posedge aclk) begin
		lim_i <= 1'($urandom);
		lim_q <= 1'($urandom);
		rssi_level <= (iq_offset_code == tgt) ? 8'h05 : {1'b1, iq_offset_code};
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	// ==========================================
	// Helpers
	function automatic logic [3:0] exp_gain(input logic [7:0] gv, input logic a, input logic l);
		return (a && l) ? gv[7:4] : gv[3:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bus write, response checked
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		chk(s_axi_wready, 32'h1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	// Bus read
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	// Read and compare a mapped register
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a, d, r);
		chk(r, rxfcg_pkg::AXI_OKAY);
		chk(d, e);
	endtask
	// Verdict
	task automatic report_and_stop();
		if (fails == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hb88570d3));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// Reset values and unmapped places
		chk(filter_rc_code, 32'h8);
		chk({lna_gain_code, filter_gain_code}, 32'hf);
		rdc(rxfcg_pkg::OFS_STATUS, 32'h80);
		rd(8'h20, d, r);
		chk(r, rxfcg_pkg::AXI_SLVERR);
		chk(d, 32'h0);
		wr(8'h24, 32'h1, rxfcg_pkg::AXI_SLVERR);
		// Forced calibration with random trim and result
		t = 2'($urandom);
		code = 4'($urandom);
		wr(rxfcg_pkg::OFS_OVERRIDE, {26'h0, t, 2'b10}, rxfcg_pkg::AXI_OKAY);
		for (n = 0; n < 50 && cal_engine_start !== 1'b1; n++) @(posedge aclk);
		chk(cal_engine_start, 32'h1);
		rdc(rxfcg_pkg::OFS_STATUS, 32'h81);
		rdc(rxfcg_pkg::OFS_OVERRIDE, {26'h0, t, 2'b00});
		cal_cmp_code <= code;
		cal_cmp_done <= 1'b1;
		repeat (6) @(posedge aclk);
		rdc(rxfcg_pkg::OFS_STATUS, {24'h0, code, 4'h2});
		chk(filter_rc_code, code);
		chk(filter_cal_trim_adjust, t);
		cal_cmp_done <= 1'b0;
		wr(rxfcg_pkg::OFS_STATUS, 32'hffffffff, rxfcg_pkg::AXI_OKAY);
		rdc(rxfcg_pkg::OFS_STATUS, {24'h0, code, 4'h2});
		// Receive entry with calibration
		wr(rxfcg_pkg::OFS_RXCTL, 32'h1, rxfcg_pkg::AXI_OKAY);
		for (n = 0; n < 100 && cal_engine_start !== 1'b1; n++) @(posedge aclk);
		chk(32'(n > 20), 32'h1);
		chk({cal_engine_start, cal_clock_enable, rx_bandgap_enable}, 32'h7);
		code = ~code;
		cal_cmp_code <= code;
		cal_cmp_done <= 1'b1;
		synth_locked_state <= 1'b1;
		for (n = 0; n < 50 && rx_enable !== 1'b1; n++) @(posedge aclk);
		chk({rx_enable, cal_clock_enable, filter_rc_code}, {2'b10, code});
		wr(rxfcg_pkg::OFS_RXCTL, 32'h0, rxfcg_pkg::AXI_OKAY);
		cal_cmp_done <= 1'b0;
		synth_locked_state <= 1'b0;
		// Skipped calibration uses the manual value
		code = 4'($urandom);
		wr(rxfcg_pkg::OFS_OVERRIDE, {24'h0, code, 4'h1}, rxfcg_pkg::AXI_OKAY);
		chk(filter_rc_code, code);
		wr(rxfcg_pkg::OFS_RXCTL, 32'h1, rxfcg_pkg::AXI_OKAY);
		synth_locked_state <= 1'b1;
		seen = 1'b0;
		for (n = 0; n < 100 && rx_enable !== 1'b1; n++) begin
			seen = seen | cal_engine_start | cal_clock_enable;
			@(posedge aclk);
		end
		chk({seen, rx_enable}, 32'h1);
		wr(rxfcg_pkg::OFS_RXCTL, 32'h0, rxfcg_pkg::AXI_OKAY);
		wr(rxfcg_pkg::OFS_OVERRIDE, 32'h0, rxfcg_pkg::AXI_OKAY);
		// Gain sets, automatic choice and bandwidth
		for (int i = 0; i < 4; i++) begin
			g = 8'($urandom);
			b = 3'($urandom);
			wr(rxfcg_pkg::OFS_GAIN, {23'h0, 1'(i >> 1), g}, rxfcg_pkg::AXI_OKAY);
			wr(rxfcg_pkg::OFS_BW, {29'h0, b}, rxfcg_pkg::AXI_OKAY);
			gain_low_sel <= 1'(i);
			repeat (5) @(posedge aclk);
			chk({lna_gain_code, filter_gain_code}, exp_gain(g, 1'(i >> 1), 1'(i)));
			chk(filter_bandwidth_sel, b);
		end
		// Offset sweep keeps the weakest reading
		tgt = 7'($urandom);
		wr(rxfcg_pkg::OFS_IQ, 32'h1, rxfcg_pkg::AXI_OKAY);
		rd(rxfcg_pkg::OFS_IQ, d, r);
		chk(d[1], 32'h1);
		rd(rxfcg_pkg::OFS_IQ, d, r);
		chk(d[1:0], 32'h2);
		for (n = 0; n < 600 && d[1] !== 1'b0; n++) rd(rxfcg_pkg::OFS_IQ, d, r);
		chk(d[14:0], {tgt, 8'h0});
		wr(rxfcg_pkg::OFS_IQ, 32'h0, rxfcg_pkg::AXI_OKAY);
		chk(iq_offset_code, 32'h0);
		wr(rxfcg_pkg::OFS_IQ, {17'h0, tgt, 8'h0}, rxfcg_pkg::AXI_OKAY);
		chk(iq_offset_code, tgt);
		report_and_stop();
	end
endmodule
// Port checker beside the design
bind rxfcg_top rxfcg_checker u_rxfcg_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cal_engine_start, .rx_enable,
	.rx_bandgap_enable, .lim_i, .lim_q, .demod_i, .demod_q);
`default_nettype wire
